// >>> common/svl_pkg.sv
// Constants shared by the servo loop tuning stage and its divider
// Operation
// (R1) Position integral time 0..50000 in 0.1 ms, default 0, immediate.
// (R2) Feedforward gain 0..100 percent, filter 0..6400 in 0.01 ms, both default 0.
// (R3) Host keeps feedforward gain at 80 percent or less on ordinary machines.
// (R4) Speed loop moves automatically between P and PI control.
// (R5) Selector: 0 torque, 1 speed, 2 acceleration, 3 position error, 4 off.
// (R6) Selector value 4 never switches, whatever the thresholds.
// (R7) Torque condition: P while torque reference exceeds level, 0..800, default 200.
// (R8) Speed condition: P while speed reference exceeds level, 0..10000, default 0.
// (R9) Acceleration condition: P while reference acceleration exceeds level, default 0.
// (R10) Position error condition: P while error exceeds level, position control only.
// (R11) Torque path: lag filter then notch stages in series, each independent.
// (R12) Each notch stage has its own enable switch.
// (R13) Lag filter time 0..65535 in 0.01 ms, default 100.
// (R14) Host keeps lag time within 1000/(2 pi x speed gain x 4) ms.
// (R15) Second-step filter 100..5000 Hz default 5000, Q 0.50..1.00 default 0.50.
// (R16) Selected quantity back at or below level returns loop to PI.
// (R17) Every parameter acts in the first control cycle after its write.
package svl_pkg;

	// ======================================================
	// Register map, byte addresses
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned PRM_W = 16;
	localparam int unsigned NUM_PRM = 12;
	localparam logic [7:0] OFS_INTEG_TIME = 8'h00;
	localparam logic [7:0] OFS_FF_GAIN = 8'h04;
	localparam logic [7:0] OFS_FF_FILT = 8'h08;
	localparam logic [7:0] OFS_SW_SEL = 8'h0c;
	localparam logic [7:0] OFS_SW_TORQUE = 8'h10;
	localparam logic [7:0] OFS_SW_SPEED = 8'h14;
	localparam logic [7:0] OFS_SW_ACCEL = 8'h18;
	localparam logic [7:0] OFS_SW_ERROR = 8'h1c;
	localparam logic [7:0] OFS_LAG_TIME = 8'h20;
	localparam logic [7:0] OFS_NOTCH_EN = 8'h24;
	localparam logic [7:0] OFS_SS_FREQ = 8'h28;
	localparam logic [7:0] OFS_SS_Q = 8'h2c;
	localparam logic [7:0] OFS_STATUS = 8'h30;

	// Parameter index order follows the offsets above
	localparam int unsigned IX_INTEG_TIME = 0;
	localparam int unsigned IX_FF_GAIN = 1;
	localparam int unsigned IX_FF_FILT = 2;
	localparam int unsigned IX_SW_SEL = 3;
	localparam int unsigned IX_SW_TORQUE = 4;
	localparam int unsigned IX_SW_SPEED = 5;
	localparam int unsigned IX_SW_ACCEL = 6;
	localparam int unsigned IX_SW_ERROR = 7;
	localparam int unsigned IX_LAG_TIME = 8;
	localparam int unsigned IX_NOTCH_EN = 9;
	localparam int unsigned IX_SS_FREQ = 10;
	localparam int unsigned IX_SS_Q = 11;

	localparam logic [PRM_W-1:0] PRM_RESET [NUM_PRM] = '{
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00c8, 16'h0000,
		16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h1388, 16'h0032
	};

	// ======================================================
	// Mode switch selections
	localparam logic [15:0] SEL_TORQUE = 16'h0000;
	localparam logic [15:0] SEL_SPEED = 16'h0001;
	localparam logic [15:0] SEL_ACCEL = 16'h0002;
	localparam logic [15:0] SEL_ERROR = 16'h0003;
	localparam logic [15:0] SEL_NONE = 16'h0004;

	// ======================================================
	// Timing and scaling
	localparam int unsigned CLOCK_HZ = 250000000;
	localparam int unsigned CTRL_PERIOD_US = 10;
	localparam int unsigned TICKS_PER_S = 1000000 / CTRL_PERIOD_US;
	localparam logic [4:0] INTEG_TICKS = 5'h0a;
	localparam logic [15:0] SS_BYPASS_HZ = 16'h1388;
	localparam logic [15:0] Q_UNIT = 16'h0064;
	localparam logic [15:0] PCT_RECIP = 16'h028f;
	localparam int unsigned PCT_SHIFT = 16;
	localparam logic [15:0] FREQ_COEF = 16'h083c;
	localparam int unsigned FREQ_SHIFT = 10;
	localparam int unsigned COEF_SHIFT = 15;
	localparam int unsigned DIV_STEPS = 32;
	localparam int unsigned NUM_NOTCH = 2;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		SVL_IDLE = 3'b001,
		SVL_CALC = 3'b010,
		SVL_APPLY = 3'b100
	} svl_state_t;

endpackage : svl_pkg

// >>> dv/svl_drive_model.sv
// Far-side model: paces control ticks and takes the torque the motor receives
`timescale 1ns/1ps
`default_nettype none
module svl_drive_model (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic fire,
	input wire logic cycle_done,
	input wire logic signed [31:0] torque_out,
	output logic ctrl_tick,
	output logic signed [31:0] applied
);
	logic [5:0] gap;
	// Spacing of at least 41 cycles keeps every tick clear of a busy cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			gap <= 6'h00;
			ctrl_tick <= 1'b0;
		end else begin
			ctrl_tick <= fire && gap == 6'h28;
			if (fire && gap == 6'h28) begin
				gap <= 6'h00;
			end else if (gap != 6'h28) begin
				gap <= gap + 6'h01;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			applied <= 32'sh0;
		end else if (cycle_done) begin
			applied <= torque_out;
		end
	end
endmodule : svl_drive_model
`default_nettype wire

// >>> dv/svl_tuning_monitor.sv
// Port checker for the servo loop tuning stage
`timescale 1ns/1ps
`default_nettype none
module svl_tuning_monitor (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic ctrl_tick,
	input wire logic position_mode,
	input wire logic signed [31:0] torque_ref,
	input wire logic signed [31:0] speed_ref,
	input wire logic signed [31:0] position_error,
	input wire logic signed [31:0] torque_out,
	input wire logic signed [31:0] feedforward_out,
	input wire logic signed [31:0] position_integral_out,
	input wire logic p_control,
	input wire logic cycle_done
);
	// ==========================================
	// Shadow parameters from accepted writes
	logic [15:0] prm [12];
	logic exp_p;
	function automatic logic [31:0] mag(input logic signed [31:0] v);
		return (v < 0) ? -v : v;
	endfunction : mag
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prm <= svl_pkg::PRM_RESET;
		end else if (s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_awaddr < 8'h30
				&& s_axi_awaddr[1:0] == 2'b00) begin
			prm[s_axi_awaddr[5:2]] <= s_axi_wdata[15:0];
		end
	end
	// Acceleration is left out: it needs the previous cycle's speed
	always_comb begin
		case (prm[svl_pkg::IX_SW_SEL])
			svl_pkg::SEL_TORQUE: exp_p = mag(torque_ref) > {16'h0000, prm[4]};
			svl_pkg::SEL_SPEED: exp_p = mag(speed_ref) > {16'h0000, prm[5]};
			svl_pkg::SEL_ERROR: exp_p = position_mode && mag(position_error) > {16'h0000, prm[7]};
			default: exp_p = 1'b0;
		endcase
	end
	// ==========================================
	// Assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_p_moves_done: assert property ($changed(p_control) |-> cycle_done)
		else $error("p_control moved outside a cycle end");
	a_switch_level: assert property (
			cycle_done && prm[3] != svl_pkg::SEL_ACCEL |-> p_control == exp_p)
		else $error("p_control disagrees with selected level");
	a_off_keeps_pi: assert property (
			cycle_done && prm[3] >= svl_pkg::SEL_NONE |-> !p_control)
		else $error("p_control set with switching off");
	a_done_latency: assert property (cycle_done |-> $past(ctrl_tick, 35))
		else $error("cycle_done not 35 cycles after tick");
	a_done_single: assert property (cycle_done |=> !cycle_done [*8])
		else $error("cycle_done repeated too soon");
	a_lag_bypass: assert property (
			cycle_done && prm[8] == 16'h0000 && prm[9] == 16'h0000
			&& prm[10] >= svl_pkg::SS_BYPASS_HZ |-> torque_out == torque_ref)
		else $error("torque path not transparent");
	a_integ_off: assert property (
			cycle_done && prm[0] == 16'h0000 |-> position_integral_out == 0)
		else $error("integral active with zero time");
	a_ff_off: assert property (
			cycle_done && prm[1] == 16'h0000 && prm[2] == 16'h0000 |-> feedforward_out == 0)
		else $error("feedforward active with zero gain");
	cover property (cycle_done && p_control && prm[3] == svl_pkg::SEL_ERROR);
	cover property ($fell(p_control));
	cover property (cycle_done && prm[9] != 16'h0000);
endmodule : svl_tuning_monitor
bind svl_tuning svl_tuning_monitor i_mon (
	.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .ctrl_tick(ctrl_tick),
	.position_mode(position_mode), .torque_ref(torque_ref), .speed_ref(speed_ref),
	.position_error(position_error), .torque_out(torque_out),
	.feedforward_out(feedforward_out), .position_integral_out(position_integral_out),
	.p_control(p_control), .cycle_done(cycle_done)
);
`default_nettype wire

// >>> dv/svl_tuning_tb.sv
// Self-checking bench for the servo loop tuning stage
`timescale 1ns/1ps
`default_nettype none
module svl_tuning_tb;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic fire = 1'b0, position_mode = 1'b0;
	logic signed [31:0] trq = 32'sh0, spd = 32'sh0, err = 32'sh0, dlt = 32'sh0;
	logic awready, wready, bvalid, arready, rvalid, p_control, cycle_done, ctrl_tick;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	logic signed [31:0] torque_out, ff_out, integ_out, applied;
	int fails = 0;
	int tests_run = 0;
	int sels [4] = '{0, 1, 3, 4};
	svl_tuning i_dut (
		.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ctrl_tick(ctrl_tick), .position_mode(position_mode), .torque_ref(trq),
		.speed_ref(spd), .position_error(err), .position_ref_delta(dlt),
		.torque_out(torque_out), .feedforward_out(ff_out),
		.position_integral_out(integ_out), .p_control(p_control), .cycle_done(cycle_done)
	);
	svl_drive_model i_drive (
		.clock(clock), .sys_rst(sys_rst), .fire(fire), .cycle_done(cycle_done),
		.torque_out(torque_out), .ctrl_tick(ctrl_tick), .applied(applied)
	);
	initial begin
		forever #2 clock = ~clock;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clock); while (bvalid !== 1'b1);
		rs = bresp;
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b0;
		@(posedge clock);
	endtask : wr
	task automatic rdw(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (rvalid !== 1'b1);
		rs = rresp;
		rd = rdata;
		arvalid <= 1'b0;
		rready <= 1'b0;
		@(posedge clock);
	endtask : rdw
	task automatic drive(input int t, input int s, input int e);
		trq <= t;
		spd <= s;
		err <= e;
	endtask : drive
	// Outputs read at the edge after cycle_done are the settled results
	task automatic run_cycle;
		fire <= 1'b1;
		do @(posedge clock); while (cycle_done !== 1'b1);
		fire <= 1'b0;
	endtask : run_cycle
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	initial begin
		#240000;
		fails++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		for (int i = 0; i < 12; i++) begin
			rdw(8'(4 * i));
			chk("reset value", {16'h0000, svl_pkg::PRM_RESET[i]}, rd);
		end
		rdw(8'h34);
		chk("unmapped read", 32'(svl_pkg::RESP_SLVERR), 32'(rs));
		wr(8'h02, 32'h0000_0001);
		chk("unaligned write", 32'(svl_pkg::RESP_SLVERR), 32'(rs));
		wr(svl_pkg::OFS_SW_SEL, 32'hffff_0003);
		chk("write response", 32'(svl_pkg::RESP_OKAY), 32'(rs));
		rdw(svl_pkg::OFS_SW_SEL);
		chk("select readback", 32'h0000_0003, rd);
		chk("read response", 32'(svl_pkg::RESP_OKAY), 32'(rs));
		wr(svl_pkg::OFS_SW_SPEED, 32'h0000_03e8);
		wr(svl_pkg::OFS_SW_ERROR, 32'h0000_0032);
		position_mode <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(svl_pkg::OFS_SW_SEL, 32'(sels[k]));
			drive(300, 1500, 60);
			run_cycle();
			chk("p above level", 32'(sels[k] != 4), 32'(p_control));
			drive(200, 1000, 50);
			run_cycle();
			chk("p at level", 32'h0, 32'(p_control));
		end
		wr(svl_pkg::OFS_SW_SEL, 32'h0000_0003);
		position_mode <= 1'b0;
		drive(0, 0, 60);
		run_cycle();
		chk("error level off position", 32'h0, 32'(p_control));
		position_mode <= 1'b1;
		wr(svl_pkg::OFS_SW_SEL, 32'h0000_0002);
		wr(svl_pkg::OFS_SW_ACCEL, 32'h0000_0064);
		drive(0, 1500, 0);
		run_cycle();
		run_cycle();
		chk("steady speed", 32'h0, 32'(p_control));
		drive(0, 1501, 0);
		run_cycle();
		chk("speed step", 32'h1, 32'(p_control));
		rdw(svl_pkg::OFS_STATUS);
		chk("status", 32'h1, rd);
		wr(svl_pkg::OFS_SW_SEL, 32'h0000_0004);
		// Lag set to zero, inside the stability bound
		wr(svl_pkg::OFS_LAG_TIME, 32'h0);
		drive(1000, 0, 0);
		run_cycle();
		chk("lag bypass", 32'sd1000, torque_out);
		// The model latches on the cycle_done edge, so its copy lands one edge later
		@(posedge clock);
		chk("motor torque", 32'sd1000, applied);
		wr(svl_pkg::OFS_LAG_TIME, 32'h1);
		drive(2000, 0, 0);
		run_cycle();
		chk("lag step", 32'sd1500, torque_out);
		wr(svl_pkg::OFS_LAG_TIME, 32'h0);
		for (int m = 1; m < 3; m++) begin
			wr(svl_pkg::OFS_NOTCH_EN, 32'(m));
			drive(100, 0, 0);
			run_cycle();
			run_cycle();
			drive(300, 0, 0);
			run_cycle();
			chk("notch stage", 32'sd200, torque_out);
		end
		wr(svl_pkg::OFS_INTEG_TIME, 32'h1);
		drive(0, 0, 100);
		run_cycle();
		run_cycle();
		chk("integral", 32'sd20, integ_out);
		wr(svl_pkg::OFS_INTEG_TIME, 32'h0);
		run_cycle();
		chk("integral off", 32'sh0, integ_out);
		// Gain held at 80 or less
		wr(svl_pkg::OFS_FF_GAIN, 32'h0000_0032);
		dlt <= 32'sd1000;
		run_cycle();
		chk("feedforward", 32'sd499, ff_out);
		print_verdict();
	end
endmodule : svl_tuning_tb
`default_nettype wire

// >>> verilog/svl_divider.sv
// Sequential signed-by-unsigned divider with fixed latency
`timescale 1ns/1ps
`default_nettype none
module svl_divider (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic signed [31:0] numer,
	input wire logic [19:0] denom,
	output logic signed [31:0] quot,
	output logic done
);

	logic [31:0] q;
	logic [20:0] rem;
	logic [19:0] d;
	logic neg;
	logic [5:0] cnt;
	logic busy;
	logic [20:0] trial;
	logic [31:0] next_q;

	assign trial = {rem[19:0], q[31]} - {1'b0, d};
	assign next_q = {q[30:0], ~trial[20]};

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			busy <= 1'b0;
			cnt <= 6'h00;
			q <= 32'h0000_0000;
			rem <= 21'h00_0000;
			d <= 20'h0_0001;
			neg <= 1'b0;
		end else if (start) begin
			busy <= 1'b1;
			cnt <= 6'h00;
			q <= numer[31] ? 32'(-numer) : numer;
			rem <= 21'h00_0000;
			// A zero divisor would fill the quotient with all ones
			d <= (denom == 20'h0_0000) ? 20'h0_0001 : denom;
			neg <= numer[31];
		end else if (busy) begin
			rem <= trial[20] ? {rem[19:0], q[31]} : trial;
			q <= next_q;
			cnt <= cnt + 6'h01;
			if (cnt == 6'(svl_pkg::DIV_STEPS - 1)) begin
				busy <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			quot <= 32'sh0000_0000;
			done <= 1'b0;
		end else begin
			done <= busy && (cnt == 6'(svl_pkg::DIV_STEPS - 1));
			if (busy && (cnt == 6'(svl_pkg::DIV_STEPS - 1))) begin
				quot <= neg ? 32'(-next_q) : next_q;
			end
		end
	end

endmodule : svl_divider
`default_nettype wire

// >>> verilog/svl_tuning.sv
// Servo loop tuning stage: integral, feedforward, mode switch, torque filters
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module svl_tuning (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ctrl_tick,
	input wire logic position_mode,
	input wire logic signed [31:0] torque_ref,
	input wire logic signed [31:0] speed_ref,
	input wire logic signed [31:0] position_error,
	input wire logic signed [31:0] position_ref_delta,
	output logic signed [31:0] torque_out,
	output logic signed [31:0] feedforward_out,
	output logic signed [31:0] position_integral_out,
	output logic p_control,
	output logic cycle_done
);

	// ======================================================
	// Register file
	logic [15:0] prm [svl_pkg::NUM_PRM];
	logic wr_fire;
	logic [3:0] wr_ix;
	logic wr_hit;
	logic [3:0] rd_ix;
	logic busy;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		for (int b = 0; b < 2; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction : merge

	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	assign wr_ix = s_axi_awaddr[5:2];
	assign wr_hit = (s_axi_awaddr[1:0] == 2'b00) && (s_axi_awaddr < svl_pkg::OFS_STATUS);
	assign rd_ix = s_axi_araddr[5:2];

	// Both channels are taken in one edge once both are offered
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= svl_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= wr_fire;
			s_axi_wready <= wr_fire;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? svl_pkg::RESP_OKAY : svl_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Parameters are live: the next control cycle reads them as stored
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < svl_pkg::NUM_PRM; i++) begin
				prm[i] <= svl_pkg::PRM_RESET[i];
			end
		end else if (wr_fire && wr_hit) begin
			prm[wr_ix] <= merge(prm[wr_ix], s_axi_wdata, s_axi_wstrb); // see (R17)
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= svl_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= svl_pkg::RESP_OKAY;
				if (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > svl_pkg::OFS_STATUS) begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= svl_pkg::RESP_SLVERR;
				end else if (s_axi_araddr == svl_pkg::OFS_STATUS) begin
					s_axi_rdata <= {30'h0, busy, p_control};
				end else begin
					s_axi_rdata <= {16'h0000, prm[rd_ix]};
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ======================================================
	// Sequencer: one pass per control tick
	svl_pkg::svl_state_t state;
	logic div_start;
	logic div_done;

	assign busy = (state != svl_pkg::SVL_IDLE);
	assign div_start = (state == svl_pkg::SVL_IDLE) && ctrl_tick;

	// A tick that lands while busy is dropped; the pass is far shorter than a tick
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= svl_pkg::SVL_IDLE;
		end else begin
			case (state)
				svl_pkg::SVL_IDLE: begin
					if (ctrl_tick) begin
						state <= svl_pkg::SVL_CALC;
					end
				end
				svl_pkg::SVL_CALC: begin
					if (div_done) begin
						state <= svl_pkg::SVL_APPLY;
					end
				end
				default: begin
					state <= svl_pkg::SVL_IDLE;
				end
			endcase
		end
	end

	// ======================================================
	// Divisions, all started on the tick
	logic signed [31:0] integ_acc;
	logic signed [31:0] ff_filt;
	logic signed [31:0] lag_out;
	logic signed [31:0] ss_lp;
	logic signed [31:0] ss_bp;
	logic signed [31:0] ff_raw;
	logic signed [63:0] ff_prod;
	logic signed [31:0] integ_step;
	logic signed [31:0] ff_step;
	logic signed [31:0] lag_step;
	logic signed [31:0] ss_damp;
	logic [19:0] integ_den;

	assign ff_prod = 64'(position_ref_delta) * $signed({1'b0, prm[svl_pkg::IX_FF_GAIN]})
		* $signed({1'b0, svl_pkg::PCT_RECIP});
	assign ff_raw = 32'(ff_prod >>> svl_pkg::PCT_SHIFT); // see (R2)
	assign integ_den = 20'(prm[svl_pkg::IX_INTEG_TIME]) * 20'(svl_pkg::INTEG_TICKS); // see (R1)

	svl_divider u_div_integ (
		.clock(clock),
		.sys_rst(sys_rst),
		.start(div_start),
		.numer(position_error),
		.denom(integ_den),
		.quot(integ_step),
		.done(div_done)
	);

	svl_divider u_div_ff (
		.clock(clock),
		.sys_rst(sys_rst),
		.start(div_start),
		.numer(ff_raw - ff_filt),
		.denom(20'(prm[svl_pkg::IX_FF_FILT]) + 20'h0_0001),
		.quot(ff_step),
		.done()
	);

	svl_divider u_div_lag (
		.clock(clock),
		.sys_rst(sys_rst),
		.start(div_start),
		.numer(torque_ref - lag_out),
		.denom(20'(prm[svl_pkg::IX_LAG_TIME]) + 20'h0_0001), // see (R13)
		.quot(lag_step),
		.done()
	);

	svl_divider u_div_damp (
		.clock(clock),
		.sys_rst(sys_rst),
		.start(div_start),
		.numer(32'(ss_bp * $signed({1'b0, svl_pkg::Q_UNIT}))),
		.denom(20'(prm[svl_pkg::IX_SS_Q])),
		.quot(ss_damp),
		.done()
	);

	// ======================================================
	// Position integral and feedforward
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			integ_acc <= 32'sh0000_0000;
		end else if (state == svl_pkg::SVL_APPLY) begin
			// Zero time constant switches the integral off and discharges it
			if (prm[svl_pkg::IX_INTEG_TIME] == 16'h0000) begin
				integ_acc <= 32'sh0000_0000; // see (R1)
			end else begin
				integ_acc <= integ_acc + integ_step; // see (R1)
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ff_filt <= 32'sh0000_0000;
		end else if (state == svl_pkg::SVL_APPLY) begin
			ff_filt <= ff_filt + ff_step; // see (R2)
		end
	end

	// ======================================================
	// Torque chain: lag, second step, notches
	logic signed [31:0] lag_new;
	logic signed [31:0] ss_hp;
	logic signed [31:0] next_bp;
	logic signed [31:0] next_lp;
	logic signed [31:0] ss_out;
	logic signed [15:0] ss_coef;
	logic ss_bypass;

	assign lag_new = lag_out + lag_step; // see (R11)
	assign ss_coef = 16'((32'(prm[svl_pkg::IX_SS_FREQ]) * 32'(svl_pkg::FREQ_COEF))
		>> svl_pkg::FREQ_SHIFT);
	assign ss_bypass = (prm[svl_pkg::IX_SS_FREQ] >= svl_pkg::SS_BYPASS_HZ); // see (R15)
	assign ss_hp = lag_new - ss_lp - ss_damp;
	assign next_bp = ss_bp + 32'((64'(ss_hp) * ss_coef) >>> svl_pkg::COEF_SHIFT);
	assign next_lp = ss_lp + 32'((64'(next_bp) * ss_coef) >>> svl_pkg::COEF_SHIFT);
	assign ss_out = ss_bypass ? lag_new : next_lp; // see (R15)

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			lag_out <= 32'sh0000_0000;
			ss_lp <= 32'sh0000_0000;
			ss_bp <= 32'sh0000_0000;
		end else if (state == svl_pkg::SVL_APPLY) begin
			lag_out <= lag_new; // see (R13)
			// Bypassed, the low-pass state tracks the input and the band-pass state clears, so re-enabling does not kick
			ss_lp <= ss_out;
			ss_bp <= ss_bypass ? 32'sh0000_0000 : next_bp;
		end
	end

	logic signed [31:0] notch_in [svl_pkg::NUM_NOTCH+1];
	logic signed [31:0] notch_d1 [svl_pkg::NUM_NOTCH];
	logic signed [31:0] notch_d2 [svl_pkg::NUM_NOTCH];

	assign notch_in[0] = ss_out;

	// Fixed zero pair at a quarter of the tick rate; stages chain in series
	for (genvar n = 0; n < svl_pkg::NUM_NOTCH; n++) begin : g_notch
		logic signed [32:0] sum;
		assign sum = 33'(notch_in[n]) + 33'(notch_d2[n]);
		assign notch_in[n+1] = prm[svl_pkg::IX_NOTCH_EN][n] ? 32'(sum >>> 1)
			: notch_in[n]; // see (R12)
		always_ff @(posedge clock) begin
			if (sys_rst) begin
				notch_d1[n] <= 32'sh0000_0000;
				notch_d2[n] <= 32'sh0000_0000;
			end else if (state == svl_pkg::SVL_APPLY) begin
				notch_d1[n] <= notch_in[n]; // see (R11)
				notch_d2[n] <= notch_d1[n];
			end
		end
	end

	// ======================================================
	// Mode switch
	logic signed [31:0] prev_speed;
	logic [31:0] abs_torque;
	logic [31:0] abs_speed;
	logic [31:0] abs_error;
	logic [31:0] abs_dv;
	logic [63:0] accel;
	logic over;

	function automatic logic [31:0] mag(input logic signed [31:0] v);
		return v[31] ? 32'(-v) : v;
	endfunction : mag

	assign abs_torque = mag(torque_ref);
	assign abs_speed = mag(speed_ref);
	assign abs_error = mag(position_error);
	assign abs_dv = mag(speed_ref - prev_speed);
	assign accel = 64'(abs_dv) * 64'(svl_pkg::TICKS_PER_S);

	always_comb begin
		case (prm[svl_pkg::IX_SW_SEL])
			svl_pkg::SEL_TORQUE: over = abs_torque > 32'(prm[svl_pkg::IX_SW_TORQUE]); // see (R7)
			svl_pkg::SEL_SPEED: over = abs_speed > 32'(prm[svl_pkg::IX_SW_SPEED]); // see (R8)
			svl_pkg::SEL_ACCEL: over = accel > 64'(prm[svl_pkg::IX_SW_ACCEL]); // see (R9)
			svl_pkg::SEL_ERROR: begin
				over = position_mode && (abs_error > 32'(prm[svl_pkg::IX_SW_ERROR])); // see (R10)
			end
			default: over = 1'b0; // see (R6)
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			p_control <= 1'b0;
			prev_speed <= 32'sh0000_0000;
		end else if (state == svl_pkg::SVL_APPLY) begin
			// Level driven both ways, so falling back below restores PI
			p_control <= over; // see (R4) see (R5) see (R16)
			prev_speed <= speed_ref;
		end
	end

	// ======================================================
	// Outputs
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			torque_out <= 32'sh0000_0000;
			feedforward_out <= 32'sh0000_0000;
			position_integral_out <= 32'sh0000_0000;
			cycle_done <= 1'b0;
		end else begin
			cycle_done <= (state == svl_pkg::SVL_APPLY);
			if (state == svl_pkg::SVL_APPLY) begin
				torque_out <= notch_in[svl_pkg::NUM_NOTCH];
				feedforward_out <= ff_filt + ff_step;
				position_integral_out <= (prm[svl_pkg::IX_INTEG_TIME] == 16'h0000)
					? 32'sh0000_0000 : integ_acc + integ_step;
			end
		end
	end

endmodule : svl_tuning
`default_nettype wire
